// [core/display_parallel_bus_driver.sv]
// 80-series parallel bus master toward a display panel controller
`timescale 1ns/1ps
// Overview of operation
// - data moves over an 8-bit parallel bus in 80-series CPU style.
// - the read strobe is low during every read transfer and high otherwise.
// - the write strobe is low during every write transfer and high otherwise.
// - select low addresses index or status, high addresses memory or register data.
// - chip select is low during a panel access and high otherwise.
// - the panel reset output pulses low, then high, before any bus access.
// - the pin pattern encodes status read, index write, memory read, data write, or none.
// - the data bus is driven during writes and released during reads.
module display_parallel_bus_driver
    import panel_bus_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic reqValid,
    input wire op_type reqOp,
    input wire logic [DATA_WIDTH-1:0] reqData,
    output logic reqReady,
    output logic respValid,
    output logic [DATA_WIDTH-1:0] respData,
    output logic panelReady,
    output logic panel_reset_n,
    output logic panelChipSelect_n,
    output logic panel_reg_or_data_select,
    output logic panelRead_n,
    output logic panelWrite_n,
    input wire logic [DATA_WIDTH-1:0] panelDataIn,
    output logic [DATA_WIDTH-1:0] panelDataOut,
    output logic panelDataOe_n
);
    state_type state_q;
    logic isRead_q;
    logic timerLoad;
    logic [COUNT_WIDTH-1:0] timerValue;
    logic timerDone;
    logic accept;
    logic reqIsRead;
    logic resetArmed_q;
    logic [COUNT_WIDTH-1:0] strobeLen_q;
    logic [COUNT_WIDTH-1:0] resetLen_q;

    assign reqIsRead = (reqOp == OP_READ_STATUS) || (reqOp == OP_READ_MEMORY);
    assign accept = (state_q == ST_IDLE) && reqValid;

    // timer reload at every phase entry
    always_comb begin
        timerLoad = 1'b0;
        timerValue = COUNT_ZERO;
        unique case (state_q)
            ST_RESET_LOW: begin
                // first enabled cycle loads the low pulse, its end loads recovery
                timerLoad = timerDone || !resetArmed_q;
                timerValue = resetArmed_q ? COUNT_WIDTH'(RESET_RECOVER_CYCLES)
                    : COUNT_WIDTH'(RESET_LOW_CYCLES);
            end
            ST_RECOVER: begin
            end
            ST_IDLE: begin
                timerLoad = accept;
                timerValue = COUNT_WIDTH'(SETUP_CYCLES);
            end
            ST_SETUP: begin
                timerLoad = timerDone;
                timerValue = COUNT_WIDTH'(STROBE_CYCLES);
            end
            ST_STROBE: begin
                timerLoad = timerDone;
                timerValue = COUNT_WIDTH'(HOLD_CYCLES);
            end
            ST_HOLD: begin
            end
        endcase
    end

    phase_timer timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clkEnable(clkEnable),
        .load(timerLoad),
        .loadValue(timerValue),
        .done(timerDone)
    );

    // sequencer: reset pulse, recovery, then setup/strobe/hold per transfer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_RESET_LOW;
        end else if (clkEnable) begin
            unique case (state_q)
                ST_RESET_LOW: if (timerDone && resetArmed_q) state_q <= ST_RECOVER;
                ST_RECOVER: if (timerDone) state_q <= ST_IDLE;
                ST_IDLE: if (accept) state_q <= ST_SETUP;
                ST_SETUP: if (timerDone) state_q <= ST_STROBE;
                ST_STROBE: if (timerDone) state_q <= ST_HOLD;
                ST_HOLD: if (timerDone) state_q <= ST_IDLE;
            endcase
        end
    end

    // marks the first enabled cycle after release, where the low pulse is loaded
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            resetArmed_q <= 1'b0;
        end else if (clkEnable) begin
            resetArmed_q <= 1'b1;
        end
    end

    // panel reset output
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            panel_reset_n <= 1'b0;
        end else if (clkEnable) begin
            panel_reset_n <= !(state_q == ST_RESET_LOW && !(timerDone && resetArmed_q));
        end
    end

    // address, direction and write data latched at acceptance
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            isRead_q <= 1'b0;
            panel_reg_or_data_select <= SELECT_INDEX;
            panelDataOut <= DATA_ZERO;
            panelDataOe_n <= 1'b1;
        end else if (clkEnable) begin
            if (accept) begin
                isRead_q <= reqIsRead;
                // select moves only in idle, where both strobes are high
                panel_reg_or_data_select <= (reqOp == OP_READ_MEMORY
                    || reqOp == OP_WRITE_DATA) ? SELECT_DATA : SELECT_INDEX;
                panelDataOut <= reqData;
                panelDataOe_n <= reqIsRead;
            end else if (state_q == ST_HOLD && timerDone) begin
                panelDataOe_n <= 1'b1;
            end
        end
    end

    // chip select and strobes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            panelChipSelect_n <= 1'b1;
            panelRead_n <= 1'b1;
            panelWrite_n <= 1'b1;
        end else if (clkEnable) begin
            if (accept) begin
                panelChipSelect_n <= 1'b0;
            end else if (state_q == ST_HOLD && timerDone) begin
                panelChipSelect_n <= 1'b1;
            end
            if (state_q == ST_SETUP && timerDone) begin
                panelRead_n <= !isRead_q;
                panelWrite_n <= isRead_q;
            end else if (state_q == ST_STROBE && timerDone) begin
                panelRead_n <= 1'b1;
                panelWrite_n <= 1'b1;
            end
        end
    end

    // user handshake and read capture at the rising read strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reqReady <= 1'b0;
            respValid <= 1'b0;
            respData <= DATA_ZERO;
            panelReady <= 1'b0;
        end else if (clkEnable) begin
            panelReady <= (state_q != ST_RESET_LOW) && (state_q != ST_RECOVER);
            reqReady <= (state_q == ST_HOLD && timerDone)
                || (state_q == ST_RECOVER && timerDone)
                || (state_q == ST_IDLE && !reqValid);
            respValid <= (state_q == ST_STROBE) && timerDone && isRead_q;
            if ((state_q == ST_STROBE) && timerDone && isRead_q) begin
                respData <= panelDataIn;
            end
        end
    end

    // helper: enabled cycles spent with a strobe low, for the strobe length check
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobeLen_q <= COUNT_ZERO;
        end else if (clkEnable) begin
            if (panelRead_n && panelWrite_n) begin
                strobeLen_q <= COUNT_ZERO;
            end else begin
                strobeLen_q <= strobeLen_q + COUNT_ONE;
            end
        end
    end

    // helper: enabled cycles the panel reset output has been low since release
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            resetLen_q <= COUNT_ZERO;
        end else if (clkEnable) begin
            if (!panel_reset_n) begin
                resetLen_q <= resetLen_q + COUNT_ONE;
            end
        end
    end

    a_strobes_exclusive: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(!panelRead_n && !panelWrite_n)) else $error("both strobes low");
    a_strobe_needs_cs: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!panelRead_n || !panelWrite_n) |-> !panelChipSelect_n)
        else $error("strobe without chip select");
    a_select_stable: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!panelRead_n || !panelWrite_n) |=> $stable(panel_reg_or_data_select)
        || (panelRead_n && panelWrite_n)) else $error("select moved under strobe");
    a_read_released: assert property (@(posedge core_clk) disable iff (!reset_n)
        !panelRead_n |-> panelDataOe_n) else $error("bus driven during read");
    a_write_driven: assert property (@(posedge core_clk) disable iff (!reset_n)
        !panelWrite_n |-> !panelDataOe_n) else $error("bus released during write");
    a_no_access_reset: assert property (@(posedge core_clk) disable iff (!reset_n)
        !panel_reset_n |-> panelChipSelect_n) else $error("access during panel reset");
    a_read_strobe_len: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(panelRead_n) && clkEnable |-> !panelRead_n[*2])
        else $error("read strobe too short");
    a_resp_after_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(respValid) |-> $past(!panelRead_n)) else $error("response without read");
    a_strobe_length: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(panelRead_n && panelWrite_n) |-> strobeLen_q == STROBE_CYCLES)
        else $error("strobe length wrong");
    a_reset_pulse_len: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(panel_reset_n) |-> resetLen_q >= RESET_LOW_CYCLES)
        else $error("panel reset pulse too short");

    c_write_seen: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(panelWrite_n));
    c_read_seen: cover property (@(posedge core_clk) disable iff (!reset_n) respValid);
    c_reset_done: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(panelReady));
    c_index_write: cover property (@(posedge core_clk) disable iff (!reset_n)
        !panelWrite_n && !panel_reg_or_data_select);
    c_status_read: cover property (@(posedge core_clk) disable iff (!reset_n)
        !panelRead_n && !panel_reg_or_data_select);
endmodule // display_parallel_bus_driver

// [core/panel_bus_pkg.sv]
// constants and types for the panel parallel bus driver
package panel_bus_pkg;
    localparam int DATA_WIDTH = 8;
    localparam int CLK_PERIOD_NS = 8;
    // reset pulse low time and recovery time before first access
    localparam int RESET_LOW_NS = 10000;
    localparam int RESET_RECOVER_NS = 20000;
    localparam int RESET_LOW_CYCLES = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_RECOVER_CYCLES =
        (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // strobe phases of one transfer
    localparam int SETUP_NS = 16;
    localparam int STROBE_NS = 48;
    localparam int HOLD_NS = 16;
    localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COUNT_WIDTH = 16;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 16'h0001;
    localparam logic [DATA_WIDTH-1:0] DATA_ZERO = 8'h00;
    // select line levels
    localparam logic SELECT_INDEX = 1'b0;
    localparam logic SELECT_DATA = 1'b1;
    typedef enum logic [1:0] {
        OP_READ_STATUS,
        OP_WRITE_INDEX,
        OP_READ_MEMORY,
        OP_WRITE_DATA
    } op_type;
    typedef enum {
        ST_RESET_LOW,
        ST_RECOVER,
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } state_type;
endpackage

// [core/phase_timer.sv]
// down counter that flags the last cycle of a timed phase
`timescale 1ns/1ps
module phase_timer
    import panel_bus_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic load,
    input wire logic [COUNT_WIDTH-1:0] loadValue,
    output logic done
);
    logic [COUNT_WIDTH-1:0] count_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= COUNT_ZERO;
        end else if (clkEnable) begin
            if (load) begin
                count_q <= loadValue - COUNT_ONE;
            end else if (count_q != COUNT_ZERO) begin
                count_q <= count_q - COUNT_ONE;
            end
        end
    end

    // done ignores load, so a reload decided from done forms no loop
    assign done = (count_q == COUNT_ZERO);
endmodule // phase_timer

// [verification/panel_model.sv]
// behavioural panel controller on the far side of the parallel bus
`timescale 1ns/1ps
module panel_model (
    input wire logic cs_n,
    input wire logic sel,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] busOut,
    input wire logic oe_n,
    output logic [7:0] busIn
);
    logic [7:0] indexQ = 8'h00;
    logic [7:0] memQ = 8'h00;
    logic [7:0] noise = 8'h5a;
    // released bus wanders so a stale value is never read back
    always #3 noise = ~noise + 8'h01;
    always @(posedge wr_n) begin
        if (!cs_n && !sel) indexQ = busOut;
        else if (!cs_n) memQ = busOut;
    end
    always_comb begin
        if (!oe_n) busIn = busOut;
        else if (!cs_n && !rd_n) busIn = sel ? memQ : (indexQ ^ 8'hc3);
        else busIn = noise;
    end
endmodule // panel_model

// [verification/tb_top.sv]
// self-checking bench for the panel parallel bus driver
`timescale 1ns/1ps
module tb_top;
    import panel_bus_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEnable = 1'b1;
    logic reqValid = 1'b0;
    op_type reqOp = OP_READ_STATUS;
    logic [7:0] reqData = 8'h00;
    logic reqReady, respValid, panelReady, panel_reset_n, panelChipSelect_n;
    logic panel_reg_or_data_select, panelRead_n, panelWrite_n, panelDataOe_n;
    logic [7:0] respData, panelDataIn, panelDataOut;
    logic [7:0] expIndex = 8'h00;
    logic [7:0] expMem = 8'h00;
    int err_total = 0;
    int n_checks = 0;
    int seed = 82;
    int cycles = 0;
    always #4 core_clk = ~core_clk;
    display_parallel_bus_driver display_parallel_bus_driver_i (.core_clk(core_clk),
        .reset_n(reset_n), .clkEnable(clkEnable), .reqValid(reqValid), .reqOp(reqOp),
        .reqData(reqData), .reqReady(reqReady), .respValid(respValid), .respData(respData),
        .panelReady(panelReady), .panel_reset_n(panel_reset_n),
        .panelChipSelect_n(panelChipSelect_n),
        .panel_reg_or_data_select(panel_reg_or_data_select), .panelRead_n(panelRead_n),
        .panelWrite_n(panelWrite_n), .panelDataIn(panelDataIn),
        .panelDataOut(panelDataOut), .panelDataOe_n(panelDataOe_n));
    panel_model panel_model_i (.cs_n(panelChipSelect_n), .sel(panel_reg_or_data_select),
        .rd_n(panelRead_n), .wr_n(panelWrite_n), .busOut(panelDataOut),
        .oe_n(panelDataOe_n), .busIn(panelDataIn));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    function automatic logic [7:0] expRead(input op_type op);
        return (op == OP_READ_MEMORY) ? expMem : (expIndex ^ 8'hc3);
    endfunction
    task automatic summarize();
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            summarize();
        end
    end
    // one transfer, with random clock-enable stalls while it runs
    task automatic transfer(input op_type op, input logic [7:0] data);
        logic gotResp;
        logic wasLow;
        logic strobed;
        gotResp = 1'b0;
        wasLow = 1'b0;
        strobed = 1'b0;
        @(negedge core_clk);
        reqValid = 1'b1;
        reqOp = op;
        reqData = data;
        do @(posedge core_clk); while (!(reqReady === 1'b1 && clkEnable));
        for (int i = 0; i < 40; i++) begin
            @(negedge core_clk);
            reqValid = 1'b0;
            if (respValid !== 1'b0) begin
                gotResp = 1'b1;
                check("respKind", 8'h01, {7'h0, ~op[0]});
                check("respData", expRead(op), respData);
            end
            check("bothStrobes", 8'h01, {7'h0, panelRead_n | panelWrite_n});
            if (panelChipSelect_n === 1'b1) begin
                check("idleStrobes", 8'h03, {6'h0, panelRead_n, panelWrite_n});
                if (wasLow && (op[0] || gotResp)) break;
            end else begin
                wasLow = 1'b1;
                check("select", {7'h0, op[1]}, {7'h0, panel_reg_or_data_select});
                if (op[0]) begin
                    check("readIdle", 8'h01, {7'h0, panelRead_n});
                    if (panelWrite_n === 1'b0) begin
                        strobed = 1'b1;
                        check("dataOut", data, panelDataOut);
                        check("oeWrite", 8'h00, {7'h0, panelDataOe_n});
                    end
                end else begin
                    check("writeIdle", 8'h01, {7'h0, panelWrite_n});
                    check("oeRead", 8'h01, {7'h0, panelDataOe_n});
                    if (panelRead_n === 1'b0) strobed = 1'b1;
                end
            end
            // random stall, never in the step that ends the transfer
            if (i < 39) clkEnable = ($random(seed) % 4) != 0;
        end
        check("done", 8'h01, {7'h0, strobed && wasLow && (op[0] || gotResp)});
        clkEnable = 1'b1;
        if (op == OP_WRITE_INDEX) expIndex = data;
        else if (op == OP_WRITE_DATA) expMem = data;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 5000 && panelReady !== 1'b1; i++) begin
            @(negedge core_clk);
            check("resetIdle", 8'h07, {5'h0, panelChipSelect_n, panelRead_n, panelWrite_n});
            if (i == 5) check("resetLow", 8'h00, {7'h0, panel_reset_n});
        end
        check("resetHigh", 8'h01, {7'h0, panel_reset_n});
        transfer(OP_WRITE_INDEX, 8'hff);
        transfer(OP_READ_STATUS, 8'h00);
        transfer(OP_WRITE_DATA, 8'h00);
        transfer(OP_READ_MEMORY, 8'h00);
        repeat (60) transfer(op_type'(2'($random(seed))), 8'($random(seed)));
        summarize();
    end
endmodule // tb_top
